// ### rtl/mis_pkg.sv
package mis_pkg;
    localparam int APB_AW = 8;
    localparam logic [7:0] OFS_OPTION = 8'h00;
    localparam logic [7:0] OFS_TCTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_STATE = 8'h10;
    localparam int OPT_CLK_BIT = 7;
    localparam int TC_FLAG_BIT = 7;
    localparam int TC_INHIBIT_BIT = 6;
    localparam logic [7:0] OPTION_RST = 8'h00;
    localparam logic TC_FLAG_RST = 1'b0;
    localparam logic TC_INHIBIT_RST = 1'b1;
    localparam int STAT_W = 4;
    localparam int ST_EXT = 0;
    localparam int ST_TMR = 1;
    localparam int ST_TRAP = 2;
    localparam int ST_RET = 3;
    localparam int CNT_W = 4;
    localparam logic [3:0] SEQ_CYCLES = 4'hB;
    localparam logic [3:0] PUSH_CYCLES = 4'h5;
    localparam logic [3:0] IMASK_CYCLE = 4'h5;
    localparam logic [3:0] POP_CYCLES = 4'h5;
    localparam int VEC_W = 16;
    localparam logic [15:0] VEC_EXT_DEF = 16'h0000;
    localparam logic [15:0] VEC_TMR_DEF = 16'h0002;
    localparam logic [15:0] VEC_TRAP_DEF = 16'h0004;
    typedef enum logic [1:0] {
        MIS_IDLE = 2'b00,
        MIS_STACK = 2'b01,
        MIS_UNSTACK = 2'b10
    } mis_state_e;
    typedef enum logic [1:0] {
        SRC_EXT = 2'b00,
        SRC_TMR = 2'b01,
        SRC_TRAP = 2'b10
    } mis_src_e;
endpackage

// ### rtl/mis_edge_latch.sv
`timescale 1ns/100ps
module mis_edge_latch
    import mis_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_async,
    input wire logic clr,
    output logic level,
    output logic fall,
    output logic pend
);
    logic s1_q, s2_q, armed_q, armed_d, pend_q, pend_d;

    assign level = s2_q;
    assign pend = pend_q;
    // falling edge only once the high level was seen
    assign fall = armed_q & ~s2_q;

    always_comb begin
        armed_d = armed_q;
        if (s2_q) begin
            armed_d = 1'b1;
        end else if (fall) begin
            armed_d = 1'b0;
        end
        // set wins over clear
        pend_d = fall | (pend_q & ~clr);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            armed_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            s1_q <= pin_async;
            s2_q <= s1_q;
            armed_q <= armed_d;
            pend_q <= pend_d;
        end
    end
endmodule

// ### rtl/mis_cyc_cnt.sv
`timescale 1ns/100ps
module mis_cyc_cnt
    import mis_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [W-1:0] len,
    output logic [W-1:0] cnt,
    output logic busy,
    output logic last
);
    logic [W-1:0] cnt_q, cnt_d;
    logic busy_q, busy_d;

    assign cnt = cnt_q;
    assign busy = busy_q;
    assign last = busy_q && (cnt_q == W'(len - W'(1)));

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        if (start) begin
            cnt_d = '0;
            busy_d = 1'b1;
        end else if (last) begin
            busy_d = 1'b0;
        end else if (busy_q) begin
            cnt_d = W'(cnt_q + W'(1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end
endmodule

// ### rtl/mis_irq_seq.sv
// Contract
// - three sources: pin, timer, trap
// - take: suspend, push, mask, vector, run
// - stack, mask, vector take 11 cycles
// - return pops state, resumes program
// - requests wait for instruction end
// - check pending requests at instruction end
// - masked requests stay latched
// - external before timer
// - trap ignores interrupt mask
// - hardware requests served before trap
// - sync pin, latch falling edge
// - option bit 7 picks oscillator
// - programming level forces crystal
// - zero count sets flag, software clears
// - inhibit bit blocks timer, reset sets
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module mis_irq_seq
    import mis_pkg::*;
#(
    parameter logic [VEC_W-1:0] VEC_EXT = VEC_EXT_DEF,
    parameter logic [VEC_W-1:0] VEC_TMR = VEC_TMR_DEF,
    parameter logic [VEC_W-1:0] VEC_TRAP = VEC_TRAP_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic int_n_pin,
    input wire logic timer_pin,
    input wire logic programming_high_level,
    input wire logic count_zero,
    input wire logic instr_done,
    input wire logic soft_trap_instr,
    input wire logic trap_return_instr,
    input wire logic cc_imask,
    output logic core_suspend,
    output logic push_strobe,
    output logic imask_set,
    output logic vec_fetch,
    output logic [VEC_W-1:0] vector_addr,
    output logic handler_start,
    output logic pop_strobe,
    output logic resume,
    output logic timer_pin_tick,
    output logic osc_rc_sel,
    output logic irq
);
    mis_state_e state_q, state_d;
    mis_src_e src_q, src_d;
    logic [VEC_W-1:0] vec_q, vec_d;
    logic trap_q, trap_d;
    logic ext_pend, ext_clr, timer_req, take, ret_go;
    logic hv1_q, hv2_q, osc_q, osc_d;
    logic [7:0] option_q, option_d;
    logic flag_q, flag_d, inhib_q, inhib_d;
    logic [STAT_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
    logic [31:0] rdata_q, rdata_d;
    logic [CNT_W-1:0] cnt;
    logic cnt_busy, cnt_last;
    logic wr, rd_setup, hit;

    mis_edge_latch u_ext (
        .pclk(pclk),
        .presetn(presetn),
        .pin_async(int_n_pin),
        .clr(ext_clr),
        .level(),
        .fall(),
        .pend(ext_pend)
    );

    mis_edge_latch u_tpin (
        .pclk(pclk),
        .presetn(presetn),
        .pin_async(timer_pin),
        .clr(1'b1),
        .level(),
        .fall(timer_pin_tick),
        .pend()
    );

    mis_cyc_cnt #(.W(CNT_W)) u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .start(take | ret_go),
        .len((state_q == MIS_UNSTACK) ? POP_CYCLES : SEQ_CYCLES),
        .cnt(cnt),
        .busy(cnt_busy),
        .last(cnt_last)
    );

    // timer request reaches the core only while not inhibited
    assign timer_req = flag_q & ~inhib_q;
    // boundary check; hardware first while unmasked, trap regardless of mask
    assign take = (state_q == MIS_IDLE) && instr_done &&
        ((!cc_imask && (ext_pend || timer_req)) || trap_q);
    assign ret_go = (state_q == MIS_IDLE) && !take && trap_return_instr;
    assign ext_clr = take && !cc_imask && ext_pend;

    always_comb begin
        state_d = state_q;
        src_d = src_q;
        vec_d = vec_q;
        trap_d = trap_q | soft_trap_instr;
        if (take) begin
            state_d = MIS_STACK;
            if (!cc_imask && ext_pend) begin
                src_d = SRC_EXT;
                vec_d = VEC_EXT;
            end else if (!cc_imask && timer_req) begin
                src_d = SRC_TMR;
                vec_d = VEC_TMR;
            end else begin
                src_d = SRC_TRAP;
                vec_d = VEC_TRAP;
                trap_d = soft_trap_instr;
            end
        end else if (ret_go) begin
            state_d = MIS_UNSTACK;
        end else if (cnt_last) begin
            state_d = MIS_IDLE;
        end
        case (state_q)
            MIS_IDLE, MIS_STACK, MIS_UNSTACK: begin
            end
            default: begin
                state_d = MIS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= MIS_IDLE;
            src_q <= SRC_EXT;
            vec_q <= '0;
            trap_q <= 1'b0;
        end else begin
            state_q <= state_d;
            src_q <= src_d;
            vec_q <= vec_d;
            trap_q <= trap_d;
        end
    end

    assign vector_addr = vec_q;
    assign core_suspend = state_q != MIS_IDLE;
    assign push_strobe = (state_q == MIS_STACK) && (cnt < PUSH_CYCLES);
    assign imask_set = (state_q == MIS_STACK) && (cnt == IMASK_CYCLE);
    assign vec_fetch = (state_q == MIS_STACK) && (cnt > IMASK_CYCLE);
    assign handler_start = (state_q == MIS_STACK) && cnt_last;
    assign pop_strobe = state_q == MIS_UNSTACK;
    assign resume = (state_q == MIS_UNSTACK) && cnt_last;

    // oscillator selection
    always_comb begin
        osc_d = option_q[OPT_CLK_BIT] & ~hv2_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv1_q <= 1'b0;
            hv2_q <= 1'b0;
            osc_q <= 1'b0;
        end else begin
            hv1_q <= programming_high_level;
            hv2_q <= hv1_q;
            osc_q <= osc_d;
        end
    end
    assign osc_rc_sel = osc_q;

    // register bus
    assign wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign hit = (paddr == OFS_OPTION) || (paddr == OFS_TCTRL) || (paddr == OFS_STATUS) ||
        (paddr == OFS_MASK) || (paddr == OFS_STATE);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign ev = {resume, handler_start && src_q == SRC_TRAP,
        handler_start && src_q == SRC_TMR, handler_start && src_q == SRC_EXT};

    always_comb begin
        option_d = option_q;
        inhib_d = inhib_q;
        mask_d = mask_q;
        flag_d = flag_q;
        stat_d = stat_q;
        rdata_d = rdata_q;
        if (wr && paddr == OFS_OPTION) begin
            option_d = pwdata[7:0];
        end
        if (wr && paddr == OFS_TCTRL) begin
            inhib_d = pwdata[TC_INHIBIT_BIT];
            flag_d = flag_q & pwdata[TC_FLAG_BIT];
        end
        if (wr && paddr == OFS_MASK) begin
            mask_d = pwdata[STAT_W-1:0];
        end
        if (wr && paddr == OFS_STATUS) begin
            stat_d = stat_q & ~pwdata[STAT_W-1:0];
        end
        // set wins over clear
        flag_d = flag_d | count_zero;
        stat_d = stat_d | ev;
        if (rd_setup) begin
            rdata_d = '0;
            case (paddr)
                OFS_OPTION: rdata_d[7:0] = option_q;
                OFS_TCTRL: begin
                    rdata_d[TC_FLAG_BIT] = flag_q;
                    rdata_d[TC_INHIBIT_BIT] = inhib_q;
                end
                OFS_STATUS: rdata_d[STAT_W-1:0] = stat_q;
                OFS_MASK: rdata_d[STAT_W-1:0] = mask_q;
                OFS_STATE: rdata_d[6:0] = {state_q, osc_q, cc_imask, trap_q, timer_req, ext_pend};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            option_q <= OPTION_RST;
            flag_q <= TC_FLAG_RST;
            inhib_q <= TC_INHIBIT_RST;
            stat_q <= '0;
            mask_q <= '0;
            rdata_q <= '0;
        end else begin
            option_q <= option_d;
            flag_q <= flag_d;
            inhib_q <= inhib_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end
    assign prdata = rdata_q;
    assign irq = |(stat_q & mask_q);

    // checks
    AST_SEQ_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        take |-> ##11 handler_start) else $error("sequence length wrong");
    AST_IMASK_AT: assert property (@(posedge pclk) disable iff (!presetn)
        take |-> !imask_set [*6] ##1 imask_set) else $error("mask not set in time");
    AST_EXT_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        take && !cc_imask && ext_pend && timer_req |=> src_q == SRC_EXT)
        else $error("timer served before external");
    AST_MASKED_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == MIS_IDLE && instr_done && cc_imask && !trap_q |-> !take)
        else $error("masked request taken");
    AST_PEND_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        ext_pend && !ext_clr |=> ext_pend) else $error("pending request lost");
    AST_TRAP_ANY: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == MIS_IDLE && instr_done && trap_q |-> take) else $error("trap not taken");
    AST_TRAP_LAST: assert property (@(posedge pclk) disable iff (!presetn)
        take && !cc_imask && (ext_pend || timer_req) |=> src_q != SRC_TRAP)
        else $error("trap before hardware");
    AST_BOUNDARY: assert property (@(posedge pclk) disable iff (!presetn)
        take |-> instr_done) else $error("taken mid instruction");
    AST_RETURN: assert property (@(posedge pclk) disable iff (!presetn)
        ret_go |-> ##1 pop_strobe [*5] ##0 resume) else $error("return sequence wrong");
    AST_OSC_XTAL: assert property (@(posedge pclk) disable iff (!presetn)
        hv2_q |=> !osc_rc_sel) else $error("crystal not forced");
    AST_TMR_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        inhib_q && !ext_pend && !trap_q |-> !take) else $error("inhibited timer taken");
    AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        count_zero |=> flag_q) else $error("flag not set");
    AST_PUSH_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
        take |=> core_suspend && push_strobe && cnt == '0)
        else $error("stacking did not start");
    AST_VEC_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == MIS_STACK |=> $stable(vector_addr))
        else $error("vector changed while stacking");
    AST_HANDLER_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        handler_start |=> !core_suspend)
        else $error("core still suspended after handler start");
    AST_RESUME_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        resume |=> !core_suspend && !pop_strobe)
        else $error("core still suspended after resume");
    AST_TRAP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        soft_trap_instr |=> trap_q)
        else $error("trap request not held");
    AST_TMR_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
        take && !cc_imask && !ext_pend && timer_req |=> src_q == SRC_TMR)
        else $error("timer request not served");
    AST_OSC_RC: assert property (@(posedge pclk) disable iff (!presetn)
        !hv2_q && option_q[OPT_CLK_BIT] |=> osc_rc_sel)
        else $error("rc oscillator not selected");
    AST_TICK_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        timer_pin_tick |=> !timer_pin_tick)
        else $error("timer pin edge seen twice");

    COV_EXT: cover property (@(posedge pclk) disable iff (!presetn) take && ext_pend);
    COV_TMR: cover property (@(posedge pclk) disable iff (!presetn) ##1 src_q == SRC_TMR);
    COV_TRAP: cover property (@(posedge pclk) disable iff (!presetn) take && cc_imask);
    COV_RET: cover property (@(posedge pclk) disable iff (!presetn) resume);
    COV_NEST: cover property (@(posedge pclk) disable iff (!presetn) take && cc_imask && timer_req);
endmodule

// ### sim/mis_core_model.sv
`timescale 1ns/100ps
module mis_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic imask_set,
    input wire logic resume,
    input wire logic core_suspend,
    input wire logic mask_wr,
    input wire logic mask_val,
    output logic cc_imask,
    output logic instr_done
);
    logic saved[$];
    int ph;

    // instruction boundary every fourth cycle, none while suspended
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_imask <= 1'b1;
            instr_done <= 1'b0;
            ph = 0;
            saved.delete();
        end else begin
            ph = (ph + 1) % 4;
            instr_done <= (ph == 0) && !core_suspend;
            if (imask_set) begin
                saved.push_back(cc_imask);
                cc_imask <= 1'b1;
            end else if (resume && saved.size() > 0) begin
                cc_imask <= saved.pop_back();
            end else if (mask_wr) begin
                cc_imask <= mask_val;
            end
        end
    end
endmodule

// ### sim/mcu_interrupt_sequencer_tb_top.sv
`timescale 1ns/100ps
module mcu_interrupt_sequencer_tb_top;
    import mis_pkg::*;
    localparam logic [15:0] V_EXT = 16'h1230;
    localparam logic [15:0] V_TMR = 16'h4560;
    localparam logic [15:0] V_TRAP = 16'h7890;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic int_n_pin = 1'b1;
    logic timer_pin = 1'b1;
    logic programming_high_level = 1'b0;
    logic count_zero = 1'b0;
    logic soft_trap_instr = 1'b0;
    logic trap_return_instr = 1'b0;
    logic mask_wr = 1'b0;
    logic mask_val = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, slv, cc_imask, instr_done, core_suspend, push_strobe, imask_set;
    logic vec_fetch, handler_start, pop_strobe, resume, timer_pin_tick, osc_rc_sel, irq;
    logic [15:0] vector_addr;
    logic [7:0] ov;
    logic [15:0] exp_q[$];
    int err_total = 0;
    int checks = 0;
    int seed = 30;
    int sc = 0;
    int pc = 0;
    int hs = 0;
    int rs = 0;
    int tk = 0;

    mis_irq_seq #(.VEC_EXT(V_EXT), .VEC_TMR(V_TMR), .VEC_TRAP(V_TRAP)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .int_n_pin, .timer_pin, .programming_high_level, .count_zero,
        .instr_done, .soft_trap_instr, .trap_return_instr, .cc_imask, .core_suspend,
        .push_strobe, .imask_set, .vec_fetch, .vector_addr, .handler_start, .pop_strobe,
        .resume, .timer_pin_tick, .osc_rc_sel, .irq);
    mis_core_model i_core (.pclk, .presetn, .imask_set, .resume, .core_suspend, .mask_wr,
        .mask_val, .cc_imask, .instr_done);

    initial begin
        forever #20 pclk = ~pclk;
    end

    task complete_run;
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task wait_ev(input int h, input int r);
        int n;
        n = 0;
        while ((hs < h || rs < r) && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk(hs, h);
        chk(rs, r);
    endtask

    task ret;
        trap_return_instr <= 1'b1;
        @(posedge pclk);
        trap_return_instr <= 1'b0;
        @(posedge pclk);
    endtask

    task trap;
        soft_trap_instr <= 1'b1;
        @(posedge pclk);
        soft_trap_instr <= 1'b0;
        @(posedge pclk);
    endtask

    // reference of sequencing: cycle counts and vector order
    always @(negedge pclk) begin
        if (push_strobe | imask_set | vec_fetch)
            sc++;
        if (pop_strobe)
            pc++;
        if (timer_pin_tick)
            tk++;
        if (handler_start) begin
            chk(sc, 11);
            chk(cc_imask, 1'b1);
            chk(core_suspend, 1'b1);
            chk(vector_addr, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
            sc = 0;
            hs++;
        end
        if (resume) begin
            chk(pc, POP_CYCLES);
            pc = 0;
            rs++;
        end
    end

    initial begin
        #400000;
        err_total++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        cyc(3);
        chk(irq, 1'b0);
        apb(1'b0, OFS_TCTRL, 32'h0);
        chk(rd, 32'h40);
        exp_q.push_back(V_TRAP);
        trap();
        wait_ev(1, 0);
        ret();
        wait_ev(1, 1);
        chk(cc_imask, 1'b1);
        apb(1'b1, OFS_TCTRL, 32'h0);
        count_zero <= 1'b1;
        @(posedge pclk);
        count_zero <= 1'b0;
        apb(1'b0, OFS_TCTRL, 32'h0);
        chk(rd, 32'h80);
        int_n_pin <= 1'b0;
        cyc(30);
        chk(hs, 1);
        apb(1'b0, OFS_STATE, 32'h0);
        chk(rd, 32'h0B);
        exp_q.push_back(V_EXT);
        exp_q.push_back(V_TMR);
        exp_q.push_back(V_TRAP);
        mask_wr <= 1'b1;
        mask_val <= 1'b0;
        @(posedge pclk);
        mask_wr <= 1'b0;
        wait_ev(2, 1);
        int_n_pin <= 1'b1;
        ret();
        trap();
        wait_ev(4, 2);
        apb(1'b1, OFS_TCTRL, 32'h40);
        ret();
        wait_ev(4, 3);
        ret();
        wait_ev(4, 4);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0F);
        chk(irq, 1'b0);
        apb(1'b1, OFS_MASK, 32'h4);
        chk(irq, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h4);
        chk(irq, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0B);
        apb(1'b1, OFS_MASK, 32'h0);
        ov = 8'($random(seed)) | 8'h80;
        apb(1'b1, OFS_OPTION, {24'h0, ov});
        apb(1'b0, OFS_OPTION, 32'h0);
        chk(rd, {24'h0, ov});
        cyc(2);
        chk(osc_rc_sel, 1'b1);
        programming_high_level <= 1'b1;
        cyc(6);
        chk(osc_rc_sel, 1'b0);
        programming_high_level <= 1'b0;
        cyc(6);
        chk(osc_rc_sel, 1'b1);
        apb(1'b1, OFS_OPTION, 32'h0);
        cyc(2);
        chk(osc_rc_sel, 1'b0);
        repeat (2) begin
            timer_pin <= 1'b0;
            cyc(4);
            timer_pin <= 1'b1;
            cyc(4);
        end
        chk(tk, 2);
        apb(1'b0, 8'h14, 32'h0);
        chk(slv, 1'b1);
        chk(rd, 32'h0);
        complete_run();
    end
endmodule
